// *** shared/clock_gen_pkg.sv ***
// ==========================================================
// Shared constants and carriers for the clock generator
// ==========================================================
package clock_gen_pkg;

	// ==========================================================
	// Register port geometry
	// ==========================================================
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h01;
	localparam logic [7:0] OFS_TRIM = 8'h02;
	localparam logic [7:0] OFS_STATUS = 8'h03;

	// Reset values (bus divider field resets to divide by two)
	localparam logic [7:0] RST_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO = 8'h40;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;

	// Field positions in control one and status/control
	localparam int SYSTEM_CLOCK_SOURCE_SELECT_HI = 7;
	localparam int SYSTEM_CLOCK_SOURCE_SELECT_LO = 6;
	localparam int SC_LOCK_BIT = 6;
	localparam int SC_FINE_BIT = 0;

	// Bus divider encodings
	localparam logic [1:0] DIV_BY_1 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_4 = 2'h2;
	localparam logic [1:0] DIV_BY_8 = 2'h3;

	// System clock source encodings (3 behaves as 0)
	localparam logic [1:0] SRC_LOOP = 2'h0;
	localparam logic [1:0] SRC_INT_REF = 2'h1;
	localparam logic [1:0] SRC_EXT_REF = 2'h2;
	localparam logic [1:0] SRC_RESERVED = 2'h3;

	// Depth of the pin synchroniser
	localparam int SYNC_STAGES = 3;

	// Control register two, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] bus_clock_divider;
		logic osc_high_range;
		logic osc_high_gain_select;
		logic bypass_loop_power_down;
		logic ext_ref_source_select;
		logic ext_ref_clock_enable;
		logic ext_ref_stop_keep;
	} ctrl_two_t;

	// Settings handed to the external oscillator
	typedef struct packed {
		logic high_range;
		logic high_gain;
		logic crystal_select;
		logic run;
	} osc_cfg_t;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Three-stage synchroniser with agreement filter
// ==========================================================
// The filtered level moves only when stages two and three agree,
// so a single metastable sample never reaches the logic behind it.
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Asynchronous inputs
	input wire logic [WIDTH-1:0] async_in,
	// Filtered levels
	output logic [WIDTH-1:0] level_out
);
	import clock_gen_pkg::*;

	logic [WIDTH-1:0] stage_ff [SYNC_STAGES];
	logic [WIDTH-1:0] level_ff;
	wire logic [WIDTH-1:0] agree = ~(stage_ff[1] ^ stage_ff[2]);
	wire logic [WIDTH-1:0] nxt_level =
		(agree & stage_ff[2]) | (~agree & level_ff);

	// Shift chain; stage zero is read only by stage one
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stage_ff <= '{default: '0};
			level_ff <= '0;
		end else if (clk_en) begin
			stage_ff[0] <= async_in;
			stage_ff[1] <= stage_ff[0];
			stage_ff[2] <= stage_ff[1];
			level_ff <= nxt_level;
		end
	end

	assign level_out = level_ff;

endmodule
`default_nettype wire

// *** core/clock_gen_ctrl.sv ***
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Clock generator: divider, oscillator and trim control
// ==========================================================
module clock_gen_ctrl (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register port
	input wire logic [clock_gen_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [clock_gen_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [clock_gen_pkg::DATA_W-1:0] reg_rdata,
	// Candidate system clocks, asynchronous to ref_clk
	input wire logic loop_clk_in,
	input wire logic int_ref_clk_in,
	input wire logic ext_ref_clk_in,
	// Lock detector of the loop, asynchronous
	input wire logic lock_detect_in,
	// Mode levels from the mode sequencer, on ref_clk
	input wire logic stop_mode,
	input wire logic bypass_mode,
	input wire logic ext_ref_mode,
	input wire logic fll_int_ref_mode,
	// Divided bus clock and registered source select
	output logic bus_clk_out,
	output logic [1:0] system_clock_source_select,
	// Oscillator and loop control
	output clock_gen_pkg::osc_cfg_t osc_cfg,
	output logic loop_power_down,
	output logic ext_ref_clock_out,
	// Internal reference trim, fine bit lowest
	output logic [8:0] int_ref_period_trim,
	// Lock indication
	output logic lock_status
);
	import clock_gen_pkg::*;

	// ==========================================================
	// Lock tracking states
	// ==========================================================
	typedef enum logic [2:0] {
		LK_UNLOCKED = 3'h1,
		LK_LOCKED = 3'h2,
		LK_RELOCK = 3'h4
	} lock_state_t;

	// ==========================================================
	// Register storage
	// ==========================================================
	logic [1:0] clk_src_ff;
	ctrl_two_t ctrl_two_ff;
	logic [7:0] trim_ff;
	logic fine_trim_ff;
	logic [7:0] rdata_ff;

	// Output and internal state flops
	logic bus_clk_ff;
	logic [2:0] div_cnt_ff;
	logic [1:0] div_act_ff;
	logic src_prev_ff;
	logic ext_mode_pre_stop_ff;
	osc_cfg_t osc_cfg_ff;
	logic loop_pd_ff;
	logic ext_out_ff;
	logic [8:0] trim_out_ff;
	logic [1:0] src_out_ff;
	lock_state_t lock_state_ff;
	logic lock_prev_ff;

	// ==========================================================
	// Synchronised clock sources and lock detector
	// ==========================================================
	logic [3:0] sync_lvl;

	pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({lock_detect_in, ext_ref_clk_in, int_ref_clk_in,
			loop_clk_in}),
		.level_out(sync_lvl)
	);

	wire logic loop_lvl = sync_lvl[0];
	wire logic int_lvl = sync_lvl[1];
	wire logic ext_lvl = sync_lvl[2];
	wire logic lock_lvl = sync_lvl[3];

	// ==========================================================
	// Address decode
	// ==========================================================
	wire logic hit_one = (reg_addr == OFS_CTRL_ONE);
	wire logic hit_two = (reg_addr == OFS_CTRL_TWO);
	wire logic hit_trim = (reg_addr == OFS_TRIM);
	wire logic hit_sc = (reg_addr == OFS_STATUS);

	wire logic wr_one = reg_wr & hit_one;
	wire logic wr_two = reg_wr & hit_two;
	wire logic wr_trim = reg_wr & hit_trim;
	wire logic wr_sc = reg_wr & hit_sc;

	// Next register values; the trim field is only ever loaded by software
	wire logic [1:0] nxt_clk_src =
		wr_one ? reg_wdata[SYSTEM_CLOCK_SOURCE_SELECT_HI:SYSTEM_CLOCK_SOURCE_SELECT_LO] : clk_src_ff;
	wire ctrl_two_t nxt_ctrl_two =
		wr_two ? ctrl_two_t'(reg_wdata) : ctrl_two_ff;
	wire logic [7:0] nxt_trim =
		wr_trim ? reg_wdata : trim_ff;
	wire logic nxt_fine =
		wr_sc ? reg_wdata[SC_FINE_BIT] : fine_trim_ff;

	// ==========================================================
	// Read data
	// ==========================================================
	// Unused bits of control one read zero; lock bit is read-only
	wire logic [7:0] rd_one = {clk_src_ff, 6'h00};
	wire logic [7:0] rd_sc =
		{1'h0, lock_status, 5'h00, fine_trim_ff};
	wire logic [7:0] rd_mux =
		hit_one ? rd_one :
		hit_two ? ctrl_two_t'(ctrl_two_ff) :
		hit_trim ? trim_ff :
		hit_sc ? rd_sc : 8'h00;
	// Data stand for exactly the cycle after the strobe
	wire logic [7:0] nxt_rdata = reg_rd ? rd_mux : 8'h00;

	// ==========================================================
	// Register process
	// ==========================================================
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_src_ff <= RST_CTRL_ONE[SYSTEM_CLOCK_SOURCE_SELECT_HI:SYSTEM_CLOCK_SOURCE_SELECT_LO];
			ctrl_two_ff <= RST_CTRL_TWO;
			trim_ff <= RST_TRIM;
			fine_trim_ff <= RST_STATUS[SC_FINE_BIT];
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			clk_src_ff <= nxt_clk_src;
			ctrl_two_ff <= nxt_ctrl_two;
			trim_ff <= nxt_trim;
			fine_trim_ff <= nxt_fine;
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// Source selection and bus divider
	// ==========================================================
	// Reserved source code falls back to the loop output
	wire logic src_lvl =
		(clk_src_ff == SRC_INT_REF) ? int_lvl :
		(clk_src_ff == SRC_EXT_REF) ? ext_lvl :
		loop_lvl;

	wire logic src_rise = src_lvl & ~src_prev_ff;

	// Ripple of the divide chain: bit n toggles every 2**n rises
	wire logic [2:0] nxt_div_cnt =
		src_rise ? 3'(div_cnt_ff + 3'h1) : div_cnt_ff;

	// Tap of the divide chain for one encoding
	function automatic logic div_tap(input logic [1:0] code,
		input logic lvl, input logic [2:0] cnt);
		logic t;
		t = lvl;
		unique case (code)
			DIV_BY_1: t = lvl;
			DIV_BY_2: t = cnt[0];
			DIV_BY_4: t = cnt[1];
			DIV_BY_8: t = cnt[2];
		endcase
		return t;
	endfunction

	wire logic [1:0] div_req = ctrl_two_ff.bus_clock_divider;
	wire logic tap_act = div_tap(div_act_ff, src_lvl, div_cnt_ff);
	wire logic tap_req = div_tap(div_req, src_lvl, div_cnt_ff);

	// A new ratio is adopted only with both clocks low: no runt pulse
	wire logic div_swap = ~tap_act & ~tap_req;
	wire logic [1:0] nxt_div_act =
		div_swap ? div_req : div_act_ff;
	wire logic nxt_bus_clk =
		div_tap(nxt_div_act, src_lvl, div_cnt_ff);

	// Divider process
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			src_prev_ff <= 1'h0;
			div_cnt_ff <= 3'h0;
			div_act_ff <= RST_CTRL_TWO[7:6];
			bus_clk_ff <= 1'h0;
			src_out_ff <= SRC_LOOP;
		end else if (clk_en) begin
			src_prev_ff <= src_lvl;
			div_cnt_ff <= nxt_div_cnt;
			div_act_ff <= nxt_div_act;
			bus_clk_ff <= nxt_bus_clk;
			src_out_ff <= clk_src_ff;
		end
	end

	// ==========================================================
	// Oscillator, loop power and external reference
	// ==========================================================
	// Remember whether the external reference was in use before stop
	wire logic nxt_ext_pre_stop =
		stop_mode ? ext_mode_pre_stop_ff : ext_ref_mode;

	// Outside stop the reference runs when enabled or in use
	wire logic run_awake =
		ctrl_two_ff.ext_ref_clock_enable | ext_ref_mode;
	wire logic run_stop = ctrl_two_ff.ext_ref_stop_keep &
		(ctrl_two_ff.ext_ref_clock_enable |
		ext_mode_pre_stop_ff);
	wire logic ext_run = stop_mode ? run_stop : run_awake;

	wire osc_cfg_t nxt_osc_cfg = '{
		high_range: ctrl_two_ff.osc_high_range,
		high_gain: ctrl_two_ff.osc_high_gain_select,
		crystal_select: ctrl_two_ff.ext_ref_source_select,
		run: ext_run
	};

	// Loop is gated off only in a bypassed mode
	wire logic nxt_loop_pd =
		ctrl_two_ff.bypass_loop_power_down & bypass_mode;

	// Gated copy of the reference; coarse, since it is resampled
	wire logic nxt_ext_out = ext_lvl & ext_run &
		ctrl_two_ff.ext_ref_clock_enable;

	// Trim drive: larger code means a longer internal period
	wire logic [8:0] nxt_trim_out =
		{trim_ff, fine_trim_ff};

	// Oscillator process
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ext_mode_pre_stop_ff <= 1'h0;
			osc_cfg_ff <= '0;
			loop_pd_ff <= 1'h0;
			ext_out_ff <= 1'h0;
			trim_out_ff <= 9'h000;
		end else if (clk_en) begin
			ext_mode_pre_stop_ff <= nxt_ext_pre_stop;
			osc_cfg_ff <= nxt_osc_cfg;
			loop_pd_ff <= nxt_loop_pd;
			ext_out_ff <= nxt_ext_out;
			trim_out_ff <= nxt_trim_out;
		end
	end

	// ==========================================================
	// Lock indication
	// ==========================================================
	// A trim rewrite with a different value in loop internal mode
	wire logic trim_disturb = wr_trim & fll_int_ref_mode &
		(reg_wdata != trim_ff);
	wire logic lock_rise = lock_lvl & ~lock_prev_ff;

	lock_state_t nxt_lock_state;

	// The detector lags the trim change, so after a forced clear we
	// wait for it to drop and rise again before showing lock
	always_comb begin
		nxt_lock_state = lock_state_ff;
		unique case (lock_state_ff)
			LK_UNLOCKED: begin
				if (lock_lvl) begin
					nxt_lock_state = LK_LOCKED;
				end
			end
			LK_LOCKED: begin
				if (trim_disturb) begin
					nxt_lock_state = LK_RELOCK;
				end else if (!lock_lvl) begin
					nxt_lock_state = LK_UNLOCKED;
				end
			end
			LK_RELOCK: begin
				if (lock_rise) begin
					nxt_lock_state = LK_LOCKED;
				end
			end
			default: begin
				nxt_lock_state = LK_UNLOCKED;
			end
		endcase
	end

	// Lock process
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lock_state_ff <= LK_UNLOCKED;
			lock_prev_ff <= 1'h0;
		end else if (clk_en) begin
			lock_state_ff <= nxt_lock_state;
			lock_prev_ff <= lock_lvl;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	// ==========================================================
	assign reg_rdata = rdata_ff;
	assign bus_clk_out = bus_clk_ff;
	assign system_clock_source_select = src_out_ff;
	assign osc_cfg = osc_cfg_ff;
	assign loop_power_down = loop_pd_ff;
	assign ext_ref_clock_out = ext_out_ff;
	assign int_ref_period_trim = trim_out_ff;
	// One-hot code: bit one of the state flop is the locked state itself
	assign lock_status = lock_state_ff[1];

endmodule
`default_nettype wire

// *** verif/clock_gen_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the clock generator control
module clock_gen_monitor (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register port
	input wire logic [clock_gen_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [clock_gen_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [clock_gen_pkg::DATA_W-1:0] reg_rdata,
	// Mode levels
	input wire logic stop_mode,
	input wire logic bypass_mode,
	input wire logic fll_int_ref_mode,
	// Outputs
	input wire logic bus_clk_out,
	input wire logic [1:0] system_clock_source_select,
	input wire clock_gen_pkg::osc_cfg_t osc_cfg,
	input wire logic loop_power_down,
	input wire logic [8:0] int_ref_period_trim,
	input wire logic lock_status
);
	import clock_gen_pkg::*;
	logic [7:0] two_ff;
	logic [7:0] trim_ff;
	logic [1:0] src_ff;
	logic fine_ff;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Shadows built from the strobes alone; frozen with the enable, as the
	// registers are, so a write during a freeze is ignored on both sides
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			two_ff <= RST_CTRL_TWO;
			trim_ff <= RST_TRIM;
			src_ff <= 2'h0;
			fine_ff <= 1'b0;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == OFS_CTRL_TWO) two_ff <= reg_wdata;
			if (reg_addr == OFS_TRIM) trim_ff <= reg_wdata;
			if (reg_addr == OFS_CTRL_ONE) src_ff <= reg_wdata[7:6];
			if (reg_addr == OFS_STATUS) fine_ff <= reg_wdata[0];
		end
	end
	// ==========================================================
	// Assertions
	// Registered outputs only move on an enabled edge, hence the guards
	rd_idle_a: assert property ($past(clk_en)
		&& !$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	rd_two_a: assert property ($past(reg_rd && clk_en)
		&& $past(reg_addr) == OFS_CTRL_TWO |-> reg_rdata == $past(two_ff))
		else $error("control two read wrong");
	trim_out_a: assert property ($past(clk_en)
		|-> int_ref_period_trim == {$past(trim_ff), $past(fine_ff)})
		else $error("trim output wrong");
	osc_cfg_a: assert property ($past(clk_en)
		|-> {osc_cfg.high_range, osc_cfg.high_gain, osc_cfg.crystal_select}
		== {$past(two_ff[5:4]), $past(two_ff[2])})
		else $error("oscillator settings wrong");
	loop_pd_a: assert property ($past(clk_en)
		|-> loop_power_down == ($past(two_ff[3]) && $past(bypass_mode)))
		else $error("loop power down wrong");
	src_copy_a: assert property ($past(clk_en)
		&& $stable(src_ff) |-> system_clock_source_select == src_ff)
		else $error("source select wrong");
	lock_drop_a: assert property (clk_en && reg_wr
		&& reg_addr == OFS_TRIM && reg_wdata != trim_ff
		&& fll_int_ref_mode && lock_status |=> !lock_status)
		else $error("lock kept over trim change");
	stop_off_a: assert property ($past(stop_mode, 2)
		&& $past(stop_mode) && !$past(two_ff[0], 2) && !$past(two_ff[0])
		&& $past(clk_en) |-> !osc_cfg.run) else $error("oscillator runs in stop");
	bus_high_a: assert property ($rose(bus_clk_out)
		|=> bus_clk_out) else $error("bus clock glitch");
	// Main scenarios reached
	cover property (lock_status ##1 !lock_status);
	cover property (stop_mode && osc_cfg.run);
	cover property ($rose(bus_clk_out));
endmodule
bind clock_gen_ctrl clock_gen_monitor mon (
	.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .stop_mode, .bypass_mode, .fll_int_ref_mode,
	.bus_clk_out, .system_clock_source_select, .osc_cfg,
	.loop_power_down, .int_ref_period_trim, .lock_status
);
`default_nettype wire

// *** verif/test_clock_gen_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the clock generator control
module test_clock_gen_ctrl;
	import clock_gen_pkg::*;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
	logic loop_clk_in = 1'b0, int_ref_clk_in = 1'b0, ext_ref_clk_in = 1'b0;
	logic lock_detect_in = 1'b0, stop_mode = 1'b0, bypass_mode = 1'b0;
	logic ext_ref_mode = 1'b0, fll_int_ref_mode = 1'b0;
	logic [7:0] reg_rdata;
	logic bus_clk_out, loop_power_down, ext_ref_clock_out, lock_status;
	logic [1:0] system_clock_source_select;
	osc_cfg_t osc_cfg;
	logic [8:0] int_ref_period_trim;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 47;
	int n_bus = 0;
	int n_ext = 0;
	int s, d, k, b0, e0;
	logic [7:0] v;
	// Sources far slower than ref_clk and never toggling on its rising edge
	always #5 ref_clk = ~ref_clk;
	always #80 loop_clk_in = ~loop_clk_in;
	always #120 int_ref_clk_in = ~int_ref_clk_in;
	always #160 ext_ref_clk_in = ~ext_ref_clk_in;
	always @(posedge bus_clk_out) n_bus++;
	always @(posedge ext_ref_clock_out) n_ext++;
	// Enable is dropped once near the end to prove that the bus clock halts and a trim write is lost
	clock_gen_ctrl uut (
		.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .loop_clk_in, .int_ref_clk_in,
		.ext_ref_clk_in, .lock_detect_in, .stop_mode, .bypass_mode,
		.ext_ref_mode, .fll_int_ref_mode, .bus_clk_out,
		.system_clock_source_select, .osc_cfg, .loop_power_down,
		.ext_ref_clock_out, .int_ref_period_trim, .lock_status
	);
	// ==========================================================
	// Helpers
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// Bus cycles leave a free edge after them so strobes never double up
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(9'(reg_rdata), 9'(exp));
		@(posedge ref_clk);
	endtask
	task automatic wait_lock();
		int i;
		for (i = 0; i < 64 && lock_status !== 1'b1; i++)
			@(posedge ref_clk);
		chk(9'(lock_status), 9'h001);
		if (i == 64) finish_test();
	endtask
	// Edge count over 1920 cycles may be off by one from sampling phase
	function automatic logic edge_ok(int n, int src, int dv);
		int span;
		span = ((src == 1) ? 24 : (src == 2) ? 32 : 16) << dv;
		return (n * span <= 1920 + span) && (n * span + span >= 1920);
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_CTRL_TWO, RST_CTRL_TWO);
		rd(OFS_TRIM, 8'h00);
		wr(8'h7F, 8'hFF);
		rd(8'h7F, 8'h00);
		// Every source against every ratio, other fields random
		for (s = 0; s < 4; s++) begin
			for (d = 0; d < 4; d++) begin
				v = {d[1:0], 6'($random(seed))};
				bypass_mode <= 1'($random(seed));
				wr(OFS_CTRL_ONE, {s[1:0], 6'h00});
				rd(OFS_CTRL_ONE, {s[1:0], 6'h00});
				wr(OFS_CTRL_TWO, v);
				rd(OFS_CTRL_TWO, v);
				repeat (300) @(posedge ref_clk);
				b0 = n_bus;
				e0 = n_ext;
				repeat (1920) @(posedge ref_clk);
				chk(9'(system_clock_source_select), 9'(s));
				chk(9'(edge_ok(n_bus - b0, s, d)), 9'h001);
				chk(9'(n_ext != e0), 9'(v[1]));
				chk(9'(loop_power_down), 9'(v[3] & bypass_mode));
				chk(9'(osc_cfg.high_gain), 9'(v[4]));
				chk(9'(osc_cfg.high_range), 9'(v[5]));
				chk(9'(osc_cfg.crystal_select), 9'(v[2]));
			end
		end
		// Trim corners and random values with the fine bit
		for (k = 0; k < 4; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
			wr(OFS_TRIM, v);
			wr(OFS_STATUS, {7'h00, k[0]});
			#1 chk(int_ref_period_trim, {v, k[0]});
			rd(OFS_TRIM, v);
			rd(OFS_STATUS, {7'h00, k[0]});
		end
		// Same trim keeps lock, a new one drops it until a fresh lock edge
		fll_int_ref_mode <= 1'b1;
		lock_detect_in <= 1'b1;
		wait_lock();
		wr(OFS_TRIM, v);
		#1 chk(9'(lock_status), 9'h001);
		wr(OFS_TRIM, ~v);
		#1 chk(9'(lock_status), 9'h000);
		repeat (20) @(posedge ref_clk);
		chk(9'(lock_status), 9'h000);
		lock_detect_in <= 1'b0;
		repeat (10) @(posedge ref_clk);
		lock_detect_in <= 1'b1;
		wait_lock();
		// Stop: enable, keep and the mode held from before stop
		for (k = 0; k < 8; k++) begin
			wr(OFS_CTRL_TWO, {6'h10, k[0], k[1]});
			ext_ref_mode <= k[2];
			repeat (4) @(posedge ref_clk);
			chk(9'(osc_cfg.run), 9'(k[0] | k[2]));
			stop_mode <= 1'b1;
			@(posedge ref_clk);
			ext_ref_mode <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk(9'(osc_cfg.run), 9'(k[1] & (k[0] | k[2])));
			stop_mode <= 1'b0;
		end
		// Freeze: the bus clock halts and a write in the frozen span is lost
		clk_en <= 1'b0;
		@(posedge ref_clk);
		b0 = n_bus;
		wr(OFS_TRIM, v);
		repeat (100) @(posedge ref_clk);
		chk(9'(n_bus - b0), 9'h000);
		clk_en <= 1'b1;
		rd(OFS_TRIM, ~v);
		finish_test();
	end
endmodule
`default_nettype wire
